/* rtl/occ_pkg.sv */
// Package for the oscillator control unlock and failover block
package occ_pkg;
   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   localparam logic [11:0] OCC_CTRL_ADDR   = 12'hF86;
   localparam logic [7:0]  OCC_UNLOCK1     = 8'hE7;
   localparam logic [7:0]  OCC_UNLOCK2     = 8'h18;
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int          OCC_IPO_BIT     = 7;
   localparam int          OCC_PRIMARY_FAIL_DETECT_EN_BIT   = 4;
   localparam int          OCC_WDT_OSC_FAIL_DETECT_EN_BIT   = 3;
   localparam int          OCC_SEL_LSB     = 0;
   localparam logic [2:0]  OCC_SEL_IPO     = 3'h0;
   localparam logic [2:0]  OCC_SEL_WDT     = 3'h3;
   localparam logic [7:0]  OCC_CTRL_RESET  = 8'h80;
   // ----------------------------------------------------------------
   // Failure detection timing
   // ----------------------------------------------------------------
   localparam int          OCC_CLK_HZ      = 40000000;
   localparam int          OCC_FAIL_HZ     = 1000;
   localparam int          OCC_FAIL_CYCLES = OCC_CLK_HZ / OCC_FAIL_HZ;

   typedef enum logic [1:0] {
      OCC_LOCKED  = 2'b00,
      OCC_FIRST   = 2'b01,
      OCC_UNLOCKD = 2'b10
   } occ_lock_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } occ_bus_t;

   typedef struct packed {
      logic       ipo_en;
      logic       primary_fail_detect_en;
      logic       wdt_osc_fail_detect_en;
      logic [2:0] clock_source_select;
   } occ_ctrl_t;
endpackage

/* rtl/occ_lock.sv */
// Unlock sequence tracker for the oscillator control register
`timescale 1ns/1ps
module occ_lock (
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   // Bus
   input  wire occ_pkg::occ_bus_t i_bus,
   // Result
   output logic                   o_commit
);
   occ_pkg::occ_lock_t state_reg;
   occ_pkg::occ_lock_t state_next;
   logic               hit;

   assign hit = i_bus.wr && (i_bus.addr == occ_pkg::OCC_CTRL_ADDR);
   assign o_commit = hit && (state_reg == occ_pkg::OCC_UNLOCKD);

   always_comb begin
      state_next = state_reg;
      if (hit) begin
         case (state_reg)
            occ_pkg::OCC_LOCKED: begin
               if (i_bus.wdata == occ_pkg::OCC_UNLOCK1) begin
                  state_next = occ_pkg::OCC_FIRST;
               end
            end
            occ_pkg::OCC_FIRST: begin
               if (i_bus.wdata == occ_pkg::OCC_UNLOCK2) begin
                  state_next = occ_pkg::OCC_UNLOCKD;
               end else begin
                  state_next = occ_pkg::OCC_LOCKED;
               end
            end
            default: begin
               state_next = occ_pkg::OCC_LOCKED;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= occ_pkg::OCC_LOCKED;
      end else begin
         state_reg <= state_next;
      end
   end

   a_commit_locks: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         o_commit |=> state_reg == occ_pkg::OCC_LOCKED)
      else $error("lock not restored after commit");
   a_unlock_order: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         o_commit |-> $past(state_reg) != occ_pkg::OCC_LOCKED)
      else $error("commit without unlock");
endmodule

/* rtl/occ_fail_det.sv */
// Primary clock failure detector
`timescale 1ns/1ps
module occ_fail_det (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst_n,
   // Monitor
   input  wire logic i_enable,
   input  wire logic i_ref_tick,
   // Result
   output logic      o_fail
);
   localparam logic [15:0] LIMIT = 16'(occ_pkg::OCC_FAIL_CYCLES);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        fail_reg;
   logic        fail_next;

   assign o_fail = fail_reg;

   // Counts reference ticks sampled on the system clock, cleared only
   // while disabled or after a failure: the reference tick comes from the
   // watchdog oscillator, so more than LIMIT ticks flags a failure
   always_comb begin
      cnt_next  = cnt_reg;
      fail_next = 1'b0;
      if (!i_enable) begin
         cnt_next = 16'h0000;
      end else if (i_ref_tick) begin
         if (cnt_reg >= LIMIT) begin
            fail_next = 1'b1;
            cnt_next  = 16'h0000;
         end else begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg  <= 16'h0000;
         fail_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         fail_reg <= fail_next;
      end
   end

   a_fail_gated: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         o_fail |-> $past(i_enable))
      else $error("failure flagged while disabled");
endmodule

/* rtl/occ_top.sv */
// Oscillator control with write lock and clock failover
// Operation
// - Two writes of E7H then 18H to the control address unlock it.
// - The next control write updates the register and relocks.
// - Any other write sequence leaves the register unchanged.
// - Other addresses between unlock writes do not break progress.
// - Other registers work normally during an unlock sequence.
// - Fail detection may be re-enabled any time after a select write.
// - Precision oscillator enable resets set and only software clears it.
// - A detected primary failure raises a non-maskable-like event.
// - A detected primary failure switches the clock to the watchdog oscillator.
// - No switchover if watchdog osc is off or already the source.
// - The detector asserts when the clock drops below 1 kHz.
`timescale 1ns/1ps
module occ_top (
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   // Register bus
   input  wire occ_pkg::occ_bus_t i_bus,
   output logic [7:0]             o_rdata,
   // Oscillator status
   input  wire logic              i_wdt_osc_on,
   input  wire logic              i_ref_tick,
   input  wire logic              i_wdt_osc_fail,
   // Clock control
   output occ_pkg::occ_ctrl_t     o_ctrl,
   output logic [2:0]             o_sys_clk_sel,
   output logic                   o_fail_nmi,
   output logic                   o_failover
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_reg;
   logic [7:0]  ctrl_next;
   logic        failover_reg;
   logic        failover_next;
   logic        nmi_reg;
   logic        nmi_next;
   logic        commit;
   logic        pri_fail;
   logic        ctrl_rd;
   logic [2:0]  sel_field;
   localparam int SEL_MSB = occ_pkg::OCC_SEL_LSB
                          + $bits(occ_pkg::OCC_SEL_WDT) - 1;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   occ_lock u_lock (
      .i_clock  (i_clock),
      .i_rst_n  (i_rst_n),
      .i_bus    (i_bus),
      .o_commit (commit)
   );

   occ_fail_det u_det (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_enable   (ctrl_reg[occ_pkg::OCC_PRIMARY_FAIL_DETECT_EN_BIT]),
      .i_ref_tick (i_ref_tick),
      .o_fail     (pri_fail)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_next     = ctrl_reg;
      failover_next = failover_reg;
      nmi_next      = 1'b0;
      if (commit) begin
         ctrl_next     = i_bus.wdata;
         failover_next = 1'b0;
      end
      if (pri_fail) begin
         nmi_next = 1'b1;
         if (i_wdt_osc_on && (sel_field != occ_pkg::OCC_SEL_WDT)) begin
            failover_next = 1'b1;
         end
      end
      if (i_wdt_osc_fail && ctrl_reg[occ_pkg::OCC_WDT_OSC_FAIL_DETECT_EN_BIT]) begin
         nmi_next = 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg     <= occ_pkg::OCC_CTRL_RESET;
         failover_reg <= 1'b0;
         nmi_reg      <= 1'b0;
      end else begin
         ctrl_reg     <= ctrl_next;
         failover_reg <= failover_next;
         nmi_reg      <= nmi_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign ctrl_rd = i_bus.rd && (i_bus.addr == occ_pkg::OCC_CTRL_ADDR);
   assign o_rdata = ctrl_rd ? ctrl_reg : 8'h00;
   assign o_ctrl.ipo_en = ctrl_reg[occ_pkg::OCC_IPO_BIT];
   assign o_ctrl.primary_fail_detect_en = ctrl_reg[occ_pkg::OCC_PRIMARY_FAIL_DETECT_EN_BIT];
   assign o_ctrl.wdt_osc_fail_detect_en = ctrl_reg[occ_pkg::OCC_WDT_OSC_FAIL_DETECT_EN_BIT];
   assign sel_field = ctrl_reg[SEL_MSB:occ_pkg::OCC_SEL_LSB];
   assign o_ctrl.clock_source_select = sel_field;
   assign o_sys_clk_sel = failover_reg ? occ_pkg::OCC_SEL_WDT
                                       : sel_field;
   assign o_fail_nmi = nmi_reg;
   assign o_failover = failover_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Last two values written to the control address, kept apart from
   // the tracker so that a commit can be held against the raw bus
   logic [7:0]  hist1_reg;
   logic [7:0]  hist1_next;
   logic [7:0]  hist2_reg;
   logic [7:0]  hist2_next;
   logic        ctrl_wr;

   assign ctrl_wr = i_bus.wr && (i_bus.addr == occ_pkg::OCC_CTRL_ADDR);

   always_comb begin
      hist1_next = hist1_reg;
      hist2_next = hist2_reg;
      if (ctrl_wr) begin
         hist1_next = i_bus.wdata;
         hist2_next = hist1_reg;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hist1_reg <= '0;
         hist2_reg <= '0;
      end else begin
         hist1_reg <= hist1_next;
         hist2_reg <= hist2_next;
      end
   end

   // ----------------------------------------------------------------
   // Unlock and update checks
   // ----------------------------------------------------------------
   a_commit_pair: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         commit |-> hist2_reg == occ_pkg::OCC_UNLOCK1
                    && hist1_reg == occ_pkg::OCC_UNLOCK2)
      else $error("commit without unlock pair");

   a_ctrl_locked: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         !commit |=> ctrl_reg == $past(ctrl_reg))
      else $error("control changed without unlock");

   a_ctrl_update: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         commit |=> ctrl_reg == $past(i_bus.wdata))
      else $error("control not updated");

   a_other_addr: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         i_bus.wr && i_bus.addr != occ_pkg::OCC_CTRL_ADDR
         |=> ctrl_reg == $past(ctrl_reg))
      else $error("other address changed control");

   a_rdata_other: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         !ctrl_rd |-> o_rdata == 8'h00)
      else $error("read data driven for other address");

   a_rdata_ctrl: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         ctrl_rd |-> o_rdata[SEL_MSB:occ_pkg::OCC_SEL_LSB]
                     == o_ctrl.clock_source_select
                  && o_rdata[occ_pkg::OCC_IPO_BIT] == o_ctrl.ipo_en)
      else $error("read data differs from control");

   // ----------------------------------------------------------------
   // Enable checks
   // ----------------------------------------------------------------
   a_primary_fail_detect_en_take: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         commit |=> o_ctrl.primary_fail_detect_en
                    == $past(i_bus.wdata[occ_pkg::OCC_PRIMARY_FAIL_DETECT_EN_BIT]))
      else $error("primary detect enable not taken");

   a_wdt_osc_fail_detect_en_take: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         commit |=> o_ctrl.wdt_osc_fail_detect_en
                    == $past(i_bus.wdata[occ_pkg::OCC_WDT_OSC_FAIL_DETECT_EN_BIT]))
      else $error("watchdog detect enable not taken");

   a_commit_clear: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         commit && !pri_fail |=> !o_failover)
      else $error("switchover kept after control write");

   a_ipo_write: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         commit |=> o_ctrl.ipo_en
                    == $past(i_bus.wdata[occ_pkg::OCC_IPO_BIT]))
      else $error("precision osc enable not taken");

   a_ipo_kept: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         $fell(o_ctrl.ipo_en) |-> $past(commit))
      else $error("precision osc cleared by hardware");

   // ----------------------------------------------------------------
   // Failure event checks
   // ----------------------------------------------------------------
   a_nmi_raise: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         pri_fail |=> o_fail_nmi)
      else $error("failure event missing");

   a_wdt_nmi: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         i_wdt_osc_fail && o_ctrl.wdt_osc_fail_detect_en |=> o_fail_nmi)
      else $error("watchdog failure event missing");

   a_nmi_cause: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         !pri_fail
         && !(i_wdt_osc_fail && o_ctrl.wdt_osc_fail_detect_en)
         |=> !o_fail_nmi)
      else $error("failure event without cause");

   a_det_off: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         !o_ctrl.primary_fail_detect_en |=> !pri_fail)
      else $error("detector fired while disabled");

   // ----------------------------------------------------------------
   // Switchover checks
   // ----------------------------------------------------------------
   a_failover_sw: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         pri_fail && !commit && i_wdt_osc_on
         && sel_field != occ_pkg::OCC_SEL_WDT |=> o_failover
         && o_sys_clk_sel == occ_pkg::OCC_SEL_WDT)
      else $error("no switchover on failure");

   a_sel_forced: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         o_failover |-> o_sys_clk_sel == occ_pkg::OCC_SEL_WDT)
      else $error("switchover without watchdog select");

   a_sel_follows: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         !o_failover |-> o_sys_clk_sel == o_ctrl.clock_source_select)
      else $error("clock select differs from control");

   a_fo_hold: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         o_failover && !commit |=> o_failover)
      else $error("switchover dropped without write");

   a_fo_exit: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         $fell(o_failover) |-> $past(commit))
      else $error("switchover cleared by hardware");

   a_no_failover: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         $rose(o_failover) |-> $past(i_wdt_osc_on))
      else $error("switchover with watchdog osc off");

   a_wdt_src_hold: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         pri_fail && !commit && sel_field == occ_pkg::OCC_SEL_WDT
         |=> o_failover == $past(o_failover))
      else $error("switchover with watchdog as source");

   a_osc_off_hold: assert property (
         @(posedge i_clock) disable iff (!i_rst_n)
         pri_fail && !commit && !i_wdt_osc_on
         |=> o_failover == $past(o_failover))
      else $error("switchover while watchdog osc off");
endmodule

/* sim/tb_occ_top.sv */
// Self-checking testbench for the oscillator control block
`timescale 1ns/1ps
module tb_occ_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [11:0] CA   = occ_pkg::OCC_CTRL_ADDR;
   localparam int          FAIL = occ_pkg::OCC_FAIL_CYCLES;
   logic               i_clock        = 1'b0;
   logic               i_rst_n        = 1'b0;
   occ_pkg::occ_bus_t  i_bus          = '0;
   logic               i_wdt_osc_on   = 1'b1;
   logic               i_ref_tick     = 1'b0;
   logic               i_wdt_osc_fail = 1'b0;
   logic [7:0]         o_rdata;
   occ_pkg::occ_ctrl_t o_ctrl;
   logic [2:0]         o_sys_clk_sel;
   logic               o_fail_nmi;
   logic               o_failover;
   int                 fails          = 0;
   int                 n_tests        = 0;
   int                 nmis           = 0;
   int                 n;
   logic [7:0]         bad [7]        = '{8'hE7, 8'h00, 8'h18, 8'h33,
                                          8'h18, 8'hE7, 8'h33};

   occ_top uut (
      .i_clock        (i_clock),
      .i_rst_n        (i_rst_n),
      .i_bus          (i_bus),
      .o_rdata        (o_rdata),
      .i_wdt_osc_on   (i_wdt_osc_on),
      .i_ref_tick     (i_ref_tick),
      .i_wdt_osc_fail (i_wdt_osc_fail),
      .o_ctrl         (o_ctrl),
      .o_sys_clk_sel  (o_sys_clk_sel),
      .o_fail_nmi     (o_fail_nmi),
      .o_failover     (o_failover)
   );

   always #12.5 i_clock = ~i_clock;

   // Count failure event pulses as they go by
   always @(negedge i_clock) begin
      if (o_fail_nmi === 1'b1) nmis++;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test;
      if (fails == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic do_reset;
      @(negedge i_clock);
      i_rst_n = 1'b0;
      repeat (16) @(negedge i_clock);
      i_rst_n = 1'b1;
   endtask

   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(negedge i_clock);
      i_bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge i_clock);
      i_bus = '0;
   endtask

   task automatic rd(logic [11:0] a, logic [7:0] exp);
      @(negedge i_clock);
      i_bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      #5;
      chk("rdata", o_rdata, exp);
      @(negedge i_clock);
      i_bus = '0;
   endtask

   task automatic put(logic [7:0] v);
      wr(CA, occ_pkg::OCC_UNLOCK1);
      wr(CA, occ_pkg::OCC_UNLOCK2);
      wr(CA, v);
   endtask

   task automatic ticks(int k);
      i_ref_tick = 1'b1;
      repeat (k) @(negedge i_clock);
      i_ref_tick = 1'b0;
      repeat (4) @(negedge i_clock);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      do_reset();
      chk("ctrl", {2'b00, o_ctrl}, 8'h20);
      chk("clksel", {5'h00, o_sys_clk_sel}, 8'h00);
      chk("events", {6'h00, o_fail_nmi, o_failover}, 8'h00);
      wr(CA, 8'hE7);
      wr(12'hF00, 8'h55);
      rd(12'hF00, 8'h00);
      wr(CA, 8'h18);
      wr(CA, 8'h5A);
      rd(CA, 8'h5A);
      chk("clksel", {5'h00, o_sys_clk_sel}, 8'h02);
      wr(CA, 8'h11);
      rd(CA, 8'h5A);
      foreach (bad[i]) wr(CA, bad[i]);
      rd(CA, 8'h5A);
      put(8'h02);
      chk("ipo", {7'h00, o_ctrl.ipo_en}, 8'h00);
      chk("primary_fail_detect_en", {7'h00, o_ctrl.primary_fail_detect_en}, 8'h00);
      put(8'h81);
      rd(CA, 8'h81);
      put(8'h89);
      rd(CA, 8'h89);
      n = nmis;
      @(negedge i_clock);
      i_wdt_osc_fail = 1'b1;
      @(negedge i_clock);
      i_wdt_osc_fail = 1'b0;
      repeat (4) @(negedge i_clock);
      chk("wdt nmi", {7'h00, nmis > n}, 8'h01);
      put(8'h91);
      n = nmis;
      ticks(FAIL / 2 - 1);
      chk("early nmi", {7'h00, nmis > n}, 8'h00);
      ticks(FAIL / 2 + 20);
      chk("nmi", {7'h00, nmis > n}, 8'h01);
      chk("failover", {7'h00, o_failover}, 8'h01);
      chk("clksel", {5'h00, o_sys_clk_sel}, occ_pkg::OCC_SEL_WDT);
      put(8'h91);
      chk("failover", {7'h00, o_failover}, 8'h00);
      chk("clksel", {5'h00, o_sys_clk_sel}, 8'h01);
      wr(CA, 8'hE7);
      wr(CA, 8'h18);
      do_reset();
      wr(CA, 8'h22);
      rd(CA, 8'h80);
      put(8'h91);
      i_wdt_osc_on = 1'b0;
      n = nmis;
      ticks(FAIL + 20);
      chk("nmi", {7'h00, nmis > n}, 8'h01);
      chk("failover", {7'h00, o_failover}, 8'h00);
      chk("clksel", {5'h00, o_sys_clk_sel}, 8'h01);
      end_of_test();
   end

   // Watchdog against a hung run
   initial begin
      #(25.0 * 95000);
      fails++;
      end_of_test();
   end
endmodule
